// ==== verilog/sc_pkg.sv ====
// Constants and types shared by the card port device and its host controller
package sc_pkg;
   localparam logic [7:0]  ADDR_BASE  = 8'h40;  // Bus address byte, direction bit 0
   localparam logic [7:0]  STATUS_RST = 8'h04;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  COR_MASK   = 8'h7a;  // Clear-on-read status bits
   localparam int ST_CARD_PRESENT = 0;
   localparam int ST_CHG = 1;
   localparam int ST_IO = 2;
   localparam int ST_SUPPLY_FAULT_FLAG = 3;
   localparam int ST_PROTECTION_FAULT_FLAG = 4;
   localparam int ST_MUTE = 5;
   localparam int ST_EARLY = 6;
   localparam int ST_ACT = 7;
   localparam int CT_START = 0;
   localparam int CT_VSEL = 2;
   localparam int CT_IOEN = 7;
   // Card clock windows
   localparam logic [15:0] MUTE_CLKS      = 16'h9c40;  // 40000
   localparam logic [15:0] EARLY_CLKS     = 16'h0190;  // 400
   localparam logic [15:0] RST_DELAY_CLKS = 16'h00c8;  // 200
   localparam logic [12:0] DEV_SYNC_RST   = 13'h1fe0;  // Lines idle high
   // Host bit timing
   localparam int CLK_NS        = 4;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QTR_INT   = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
   localparam logic [7:0] SCL_QTR = 8'(SCL_QTR_INT);
   // Host register offsets
   localparam logic [7:0] WB_DATA   = 8'h00;
   localparam logic [7:0] WB_CMD    = 8'h04;
   localparam logic [7:0] WB_RESULT = 8'h08;
   localparam logic [7:0] WB_ASEL   = 8'h0c;
   localparam int CMD_WRITE = 0;
   localparam int CMD_READ = 1;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK, I_SKIP} slave_e;
   typedef enum logic [1:0] {S_OFF, S_PWR, S_ATR, S_ON} sess_e;
   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} master_e;
endpackage : sc_pkg

// ==== verilog/i2c_link_if.sv ====
// Two-wire link between host controller and card port device
`timescale 1ns/1ns
interface i2c_link_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic scl_s_o;
   logic scl_s_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // Wired-AND of open-drain drivers with pull-up
   assign scl = (~scl_m_oe | scl_m_o) & (~scl_s_oe | scl_s_o);
   assign sda = (~sda_m_oe | sda_m_o) & (~sda_s_oe | sda_s_o);
   modport ctrl (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
   modport dev (output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe, input scl, sda);
endinterface : i2c_link_if

// ==== verilog/sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_sys, // System clock
   input  wire logic         rst,     // Async reset
   input  wire logic [W-1:0] d,       // Asynchronous inputs
   output logic      [W-1:0] q        // Synchronised outputs
);
   logic [W-1:0] m_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m_q <= RST_VAL;
         q   <= RST_VAL;
      end else begin
         m_q <= d;
         q   <= m_q;
      end
   end
endmodule : sync2

// ==== verilog/card_port_dev.sv ====
// Card port device: two-wire slave, control and status registers, session sequencer
//
// The address map is this design's own decision.
`timescale 1ns/1ns
module card_port_dev #(
   parameter logic [15:0] MUTE_CLKS = sc_pkg::MUTE_CLKS
) (
   input  wire logic       clk_sys,          // System clock
   input  wire logic       rst,              // Async reset
   i2c_link_if.dev         link,             // Two-wire link
   input  wire logic       addr_sel0,        // Address select 0
   input  wire logic       addr_sel1,        // Address select 1
   input  wire logic       addr_sel2,        // Address select 2
   input  wire logic       card_present,     // Card in slot
   input  wire logic       supply_fault,     // Supply supervisor fault
   input  wire logic       over_current,     // Card current over limit
   input  wire logic       over_heat,        // Die over temperature
   input  wire logic       card_clk,         // Card clock
   input  wire logic [2:0] card_line_i,      // Card data, card_aux_line1, card_aux_line2 level
   output logic      [2:0] card_line_o,      // Card lines drive value
   output logic      [2:0] card_line_oe,     // Card lines pulled low
   input  wire logic [2:0] host_side_line_i, // Host data, card_aux_line1, card_aux_line2 level
   output logic      [2:0] host_side_line_o, // Host lines drive value
   output logic      [2:0] host_side_line_oe,// Host lines pulled low
   output logic            card_rst,         // Card reset, high released
   output logic            vcc_on,           // Card supply on
   output logic            vcc_3v,           // Card supply 3 V select
   output logic            int_n,            // Interrupt, active low
   output logic      [7:0] ctrl_byte         // Control register
);
   logic [12:0] s;
   logic [12:0] p_q;
   sync2 #(.W(13), .RST_VAL(sc_pkg::DEV_SYNC_RST)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       ({link.sda, link.scl, host_side_line_i, card_line_i,
                 card_clk, over_heat, over_current, supply_fault, card_present}),
      .q       (s)
   );
   wire scl = s[11];
   wire sda = s[12];
   wire scl_rise = scl & ~p_q[11];
   wire scl_fall = ~scl & p_q[11];
   wire start_c  = scl & p_q[11] & p_q[12] & ~sda;
   wire stop_c   = scl & p_q[11] & ~p_q[12] & sda;
   wire cclk_edge = s[4] & ~p_q[4];
   wire atr_edge  = ~s[5] & p_q[5];

   // Two-wire slave
   sc_pkg::slave_e st_q, st_d;
   logic [3:0] bc_q, bc_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] snap_q, snap_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic       sdo_q, sdo_d;
   logic       clr_d, clr_q;
   logic [7:0] status;
   logic [6:0] my_addr;
   assign my_addr = {sc_pkg::ADDR_BASE[7:4], addr_sel2, addr_sel1, addr_sel0};

   always_comb begin
      st_d   = st_q;
      bc_d   = bc_q;
      sh_d   = sh_q;
      snap_d = snap_q;
      ctrl_d = ctrl_q;
      sdo_d  = sdo_q;
      clr_d  = 1'b0;
      if (start_c) begin
         st_d  = sc_pkg::I_ADDR;
         bc_d  = 4'h0;
         sdo_d = 1'b0;
      end else if (stop_c) begin
         st_d  = sc_pkg::I_IDLE;
         sdo_d = 1'b0;
      end else begin
         unique case (st_q)
            sc_pkg::I_IDLE, sc_pkg::I_SKIP: ;
            sc_pkg::I_ADDR, sc_pkg::I_WR: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda};
                  bc_d = bc_q + 4'h1;
               end else if (scl_fall && bc_q == 4'h8) begin
                  if (st_q == sc_pkg::I_WR) begin
                     ctrl_d = sh_q;
                     sdo_d  = 1'b1;
                     st_d   = sc_pkg::I_WACK;
                  end else if (sh_q[7:1] == my_addr) begin
                     sdo_d = 1'b1;
                     st_d  = sc_pkg::I_AACK;
                  end else begin
                     st_d = sc_pkg::I_SKIP;
                  end
               end
            end
            sc_pkg::I_AACK: begin
               if (scl_fall) begin
                  bc_d = 4'h0;
                  if (sh_q[0]) begin
                     sh_d  = status;
                     snap_d = status;
                     sdo_d = ~status[7];
                     st_d  = sc_pkg::I_RD;
                  end else begin
                     sdo_d = 1'b0;
                     st_d  = sc_pkg::I_WR;
                  end
               end
            end
            sc_pkg::I_WACK: begin
               if (scl_fall) begin
                  sdo_d = 1'b0;
                  st_d  = sc_pkg::I_SKIP;
               end
            end
            sc_pkg::I_RD: begin
               if (scl_fall) begin
                  bc_d = bc_q + 4'h1;
                  if (bc_q == 4'h7) begin
                     sdo_d = 1'b0;
                     clr_d = 1'b1;
                     st_d  = sc_pkg::I_RACK;
                  end else begin
                     sh_d  = {sh_q[6:0], 1'b0};
                     sdo_d = ~sh_q[6];
                  end
               end
            end
            sc_pkg::I_RACK: begin
               if (scl_rise) begin
                  st_d = sc_pkg::I_SKIP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q   <= sc_pkg::I_IDLE;
         bc_q   <= 4'h0;
         sh_q   <= 8'h00;
         snap_q <= 8'h00;
         ctrl_q <= sc_pkg::CTRL_RST;
         sdo_q  <= 1'b0;
         clr_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         bc_q   <= bc_d;
         sh_q   <= sh_d;
         snap_q <= snap_d;
         ctrl_q <= ctrl_d;
         sdo_q  <= sdo_d;
         clr_q  <= clr_d;
      end
   end

   assign link.sda_s_o  = 1'b0;
   assign link.sda_s_oe = sdo_q;
   assign link.scl_s_o  = 1'b0;
   assign link.scl_s_oe = 1'b0;
   assign ctrl_byte     = ctrl_q;
   assign vcc_3v        = ctrl_q[sc_pkg::CT_VSEL];

   // Session sequencer
   sc_pkg::sess_e ss_q, ss_d;
   logic [15:0] cnt_q, cnt_d;
   logic        go_q, go_d;
   logic        mute_set, early_set, sess_new, abort;
   wire         fault = s[1] | s[2] | s[3];

   always_comb begin
      ss_d      = ss_q;
      cnt_d     = cnt_q;
      go_d      = ctrl_q[sc_pkg::CT_START];
      mute_set  = 1'b0;
      early_set = 1'b0;
      sess_new  = 1'b0;
      abort     = ~ctrl_q[sc_pkg::CT_START] | fault | ~s[0];
      unique case (ss_q)
         sc_pkg::S_OFF: begin
            if (ctrl_q[sc_pkg::CT_START] && !go_q && !abort) begin
               ss_d     = sc_pkg::S_PWR;
               cnt_d    = 16'h0000;
               sess_new = 1'b1;
            end
         end
         sc_pkg::S_PWR: begin
            if (cclk_edge) begin
               cnt_d = cnt_q + 16'h0001;
               if (cnt_q == sc_pkg::RST_DELAY_CLKS - 16'h0001) begin
                  ss_d  = sc_pkg::S_ATR;
                  cnt_d = 16'h0000;
               end
            end
         end
         sc_pkg::S_ATR: begin
            if (atr_edge) begin
               early_set = cnt_q < sc_pkg::EARLY_CLKS;
               ss_d      = sc_pkg::S_ON;
            end else if (cclk_edge) begin
               cnt_d = cnt_q + 16'h0001;
               if (cnt_q == MUTE_CLKS - 16'h0001) begin
                  mute_set = 1'b1;
                  ss_d     = sc_pkg::S_ON;
               end
            end
         end
         sc_pkg::S_ON: ;
      endcase
      if (ss_q != sc_pkg::S_OFF && abort) begin
         ss_d = sc_pkg::S_OFF;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ss_q  <= sc_pkg::S_OFF;
         cnt_q <= 16'h0000;
         go_q  <= 1'b0;
      end else begin
         ss_q  <= ss_d;
         cnt_q <= cnt_d;
         go_q  <= go_d;
      end
   end

   // Status flags and interrupt
   logic [7:0] fl_q, fl_d, set_v;
   logic       rst_q, rst_d, von_q, von_d, int_n_q, int_n_d;

   always_comb begin
      set_v = 8'h00;
      set_v[sc_pkg::ST_CHG]   = s[0] ^ p_q[0];
      set_v[sc_pkg::ST_SUPPLY_FAULT_FLAG]  = s[1];
      set_v[sc_pkg::ST_PROTECTION_FAULT_FLAG]  = (s[2] | s[3]) & (ss_q != sc_pkg::S_OFF);
      set_v[sc_pkg::ST_MUTE]  = mute_set;
      set_v[sc_pkg::ST_EARLY] = early_set;
      fl_d = fl_q;
      if (clr_q) begin
         fl_d = fl_q & ~(snap_q & sc_pkg::COR_MASK);
      end
      if (sess_new) begin
         fl_d[sc_pkg::ST_MUTE]  = 1'b0;
         fl_d[sc_pkg::ST_EARLY] = 1'b0;
      end
      fl_d    = fl_d | set_v;
      rst_d   = ss_d == sc_pkg::S_ATR || ss_d == sc_pkg::S_ON;
      von_d   = ss_d != sc_pkg::S_OFF;
      int_n_d = ~|fl_d;
   end

   always_comb begin
      status = fl_q;
      status[sc_pkg::ST_CARD_PRESENT] = s[0];
      status[sc_pkg::ST_IO]   = s[5];
      status[sc_pkg::ST_ACT]  = von_q;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fl_q    <= 8'h00;
         p_q     <= sc_pkg::DEV_SYNC_RST;
         rst_q   <= 1'b0;
         von_q   <= 1'b0;
         int_n_q <= 1'b1;
      end else begin
         fl_q    <= fl_d;
         p_q     <= s;
         rst_q   <= rst_d;
         von_q   <= von_d;
         int_n_q <= int_n_d;
      end
   end

   assign card_rst = rst_q;
   assign vcc_on   = von_q;
   assign int_n    = int_n_q;

   // Line relays: pulled-low side copied to the other, with hold-off against latching
   for (genvar i = 0; i < 3; i++) begin : g_relay
      logic [3:0] hc_q, hc_d, ch_q, ch_d;
      always_comb begin
         hc_d = {hc_q[2:0], ctrl_q[sc_pkg::CT_IOEN] & ~s[8+i] & ~|ch_q};
         ch_d = {ch_q[2:0], ctrl_q[sc_pkg::CT_IOEN] & ~s[5+i] & ~|hc_q & ~hc_d[0]};
      end
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            hc_q <= 4'h0;
            ch_q <= 4'h0;
         end else begin
            hc_q <= hc_d;
            ch_q <= ch_d;
         end
      end
      assign card_line_o[i]       = 1'b0;
      assign card_line_oe[i]      = hc_q[0];
      assign host_side_line_o[i]  = 1'b0;
      assign host_side_line_oe[i] = ch_q[0];
   end
endmodule : card_port_dev

// ==== verilog/card_port_host.sv ====
// Host controller: Wishbone slave registers driving a two-wire bus master
`timescale 1ns/1ns
module card_port_host (
   input  wire logic        clk_sys,  // System clock
   input  wire logic        rst,      // Async reset
   i2c_link_if.ctrl         link,     // Two-wire link
   input  wire logic        wb_cyc_i, // Bus cycle
   input  wire logic        wb_stb_i, // Bus strobe
   input  wire logic        wb_we_i,  // Write enable
   input  wire logic [7:0]  wb_adr_i, // Byte address
   input  wire logic [3:0]  wb_sel_i, // Byte lanes
   input  wire logic [31:0] wb_dat_i, // Write data
   output logic      [31:0] wb_dat_o, // Read data
   output logic             wb_ack_o  // Acknowledge
);
   logic sda;
   sync2 #(.W(1), .RST_VAL(1'b1)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (link.sda),
      .q       (sda)
   );

   sc_pkg::master_e ms_q, ms_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0]  data_q, data_d, txb_q, txb_d, rxb_q, rxb_d, res_q, res_d, qc_q, qc_d;
   logic [3:0]  bi_q, bi_d;
   logic [2:0]  asel_q, asel_d;
   logic [1:0]  ph_q, ph_d;
   logic        ack_q, ack_d, by_q, by_d, rw_q, rw_d, nack_q, nack_d;
   logic        scl_q, scl_d, sda_q, sda_d, wr, tick;

   always_comb begin
      ms_d   = ms_q;
      dat_d  = dat_q;
      data_d = data_q;
      txb_d  = txb_q;
      rxb_d  = rxb_q;
      res_d  = res_q;
      bi_d   = bi_q;
      asel_d = asel_q;
      ph_d   = ph_q;
      by_d   = by_q;
      rw_d   = rw_q;
      nack_d = nack_q;
      scl_d  = scl_q;
      sda_d  = sda_q;
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      wr     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
      tick   = qc_q == sc_pkg::SCL_QTR - 8'h01;
      qc_d   = (tick || ms_q == sc_pkg::M_IDLE) ? 8'h00 : qc_q + 8'h01;
      if (ack_d) begin
         unique case (wb_adr_i)
            sc_pkg::WB_DATA:   dat_d = {24'h000000, data_q};
            sc_pkg::WB_RESULT: dat_d = {22'h000000, nack_q, ms_q != sc_pkg::M_IDLE, res_q};
            sc_pkg::WB_ASEL:   dat_d = {29'h00000000, asel_q};
            default:           dat_d = 32'h00000000;
         endcase
      end
      if (wr && wb_adr_i == sc_pkg::WB_DATA) begin
         data_d = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == sc_pkg::WB_ASEL) begin
         asel_d = wb_dat_i[2:0];
      end
      unique case (ms_q)
         sc_pkg::M_IDLE: begin
            scl_d = 1'b1;
            sda_d = 1'b1;
            if (wr && wb_adr_i == sc_pkg::WB_CMD
                && (wb_dat_i[sc_pkg::CMD_WRITE] || wb_dat_i[sc_pkg::CMD_READ])) begin
               rw_d   = wb_dat_i[sc_pkg::CMD_READ];
               txb_d  = {sc_pkg::ADDR_BASE[7:4], asel_q, wb_dat_i[sc_pkg::CMD_READ]};
               nack_d = 1'b0;
               by_d   = 1'b0;
               bi_d   = 4'h0;
               ph_d   = 2'h0;
               ms_d   = sc_pkg::M_START;
            end
         end
         sc_pkg::M_START: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h0) begin
                  sda_d = 1'b0;
               end else begin
                  scl_d = 1'b0;
                  ph_d  = 2'h0;
                  ms_d  = sc_pkg::M_BIT;
               end
            end
         end
         sc_pkg::M_BIT: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: sda_d = (bi_q == 4'h8 || (by_q && rw_q)) ? 1'b1 : txb_q[7];
                  2'h1: scl_d = 1'b1;
                  2'h2: begin
                     if (bi_q != 4'h8) begin
                        rxb_d = {rxb_q[6:0], sda};
                     end else if (sda && !by_q) begin
                        nack_d = 1'b1;
                     end
                  end
                  2'h3: begin
                     scl_d = 1'b0;
                     bi_d  = bi_q + 4'h1;
                     txb_d = {txb_q[6:0], 1'b0};
                     if (bi_q == 4'h8) begin
                        if (by_q || nack_q) begin
                           ms_d = sc_pkg::M_STOP;
                        end else begin
                           by_d  = 1'b1;
                           bi_d  = 4'h0;
                           txb_d = data_q;
                        end
                     end
                  end
               endcase
            end
         end
         sc_pkg::M_STOP: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: sda_d = 1'b0;
                  2'h1: scl_d = 1'b1;
                  2'h2: sda_d = 1'b1;
                  2'h3: begin
                     ms_d = sc_pkg::M_IDLE;
                     if (rw_q && !nack_q) begin
                        res_d = rxb_q;
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ms_q   <= sc_pkg::M_IDLE;
         dat_q  <= 32'h00000000;
         data_q <= 8'h00;
         txb_q  <= 8'h00;
         rxb_q  <= 8'h00;
         res_q  <= 8'h00;
         qc_q   <= 8'h00;
         bi_q   <= 4'h0;
         asel_q <= 3'h0;
         ph_q   <= 2'h0;
         ack_q  <= 1'b0;
         by_q   <= 1'b0;
         rw_q   <= 1'b0;
         nack_q <= 1'b0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         ms_q   <= ms_d;
         dat_q  <= dat_d;
         data_q <= data_d;
         txb_q  <= txb_d;
         rxb_q  <= rxb_d;
         res_q  <= res_d;
         qc_q   <= qc_d;
         bi_q   <= bi_d;
         asel_q <= asel_d;
         ph_q   <= ph_d;
         ack_q  <= ack_d;
         by_q   <= by_d;
         rw_q   <= rw_d;
         nack_q <= nack_d;
         scl_q  <= scl_d;
         sda_q  <= sda_d;
      end
   end

   assign wb_ack_o      = ack_q;
   assign wb_dat_o      = dat_q;
   assign link.scl_m_o  = 1'b0;
   assign link.scl_m_oe = ~scl_q;
   assign link.sda_m_o  = 1'b0;
   assign link.sda_m_oe = ~sda_q;
endmodule : card_port_host

// ==== verif/card_link_assertions.sv ====
// Checker for the two-wire link and card session pins
`timescale 1ns/1ns
module card_link_assertions (
   input wire logic       clk_sys,      // Clock
   input wire logic       rst,          // Reset
   input wire logic       scl,          // Bus clock
   input wire logic       sda,          // Bus data
   input wire logic       scl_s_oe,     // Device clock pull
   input wire logic       sda_s_oe,     // Device data pull
   input wire logic       card_present, // Card in
   input wire logic       over_current, // Current fault
   input wire logic       int_n,        // Interrupt
   input wire logic       vcc_on,       // Supply on
   input wire logic       vcc_3v,       // 3 V select
   input wire logic       card_rst,     // Card reset
   input wire logic [7:0] ctrl_byte     // Control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence start_s; $fell(sda) && scl; endsequence
   sequence ack_s; ##[0:8] sda_s_oe; endsequence
   no_stretch_a: assert property (!scl_s_oe) else $error("device pulled clock");
   dev_sda_a: assert property ($rose(sda_s_oe) |-> !scl) else $error("data pulled in clock high");
   sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe)) else $error("data moved");
   no_start_a: assert property (start_s |-> !sda_s_oe) else $error("device made start");
   data_ack_a: assert property ($changed(ctrl_byte) |-> ack_s) else $error("no data ack");
   card_present_int_a: assert property ($rose(card_present) |-> ##[1:6] !int_n) else $error("no insert int");
   vsel_a: assert property ($changed(ctrl_byte[2]) |-> ##[0:2] vcc_3v == ctrl_byte[2]) else $error("vsel");
   start_on_a: assert property ($rose(ctrl_byte[0]) && card_present |-> ##[1:4] vcc_on) else $error("no on");
   stop_off_a: assert property ($fell(ctrl_byte[0]) |-> ##[1:4] !vcc_on) else $error("no off");
   oc_off_a: assert property (over_current && vcc_on |-> ##[1:6] !vcc_on && !int_n) else $error("oc");
   rst_vcc_a: assert property (card_rst |-> vcc_on) else $error("reset without supply");
endmodule : card_link_assertions

// ==== verif/tb.sv ====
// Testbench joining host controller and card port device
`timescale 1ns/1ns
module tb;
   logic        clk_sys, rst, card_clk, card_present, supply_fault, over_current, over_heat;
   logic        wb_cyc, wb_stb, wb_we, wb_ack, card_rst, vcc_on, vcc_3v, int_n;
   logic [7:0]  wb_adr, ctrl_byte;
   logic [31:0] wb_dat, wb_rdat, res;
   logic [2:0]  card_drv, card_line_oe, host_side_line_oe;
   int          err_count, n_compared, cyc_n;
   i2c_link_if link ();
   card_port_dev #(.MUTE_CLKS(16'h01c2)) i_card_port_dev (.clk_sys(clk_sys), .rst(rst), .link(link),
      .addr_sel0(1'b1), .addr_sel1(1'b0), .addr_sel2(1'b1), .card_present(card_present),
      .supply_fault(supply_fault), .over_current(over_current), .over_heat(over_heat), .card_clk(card_clk),
      .card_line_i(card_drv & ~card_line_oe), .card_line_o(), .card_line_oe(card_line_oe),
      .host_side_line_i(~host_side_line_oe), .host_side_line_o(), .host_side_line_oe(host_side_line_oe),
      .card_rst(card_rst), .vcc_on(vcc_on), .vcc_3v(vcc_3v), .int_n(int_n), .ctrl_byte(ctrl_byte));
   card_port_host i_card_port_host (.clk_sys(clk_sys), .rst(rst), .link(link), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   card_link_assertions i_card_link_assertions (.clk_sys(clk_sys), .rst(rst), .scl(link.scl),
      .sda(link.sda), .scl_s_oe(link.scl_s_oe), .sda_s_oe(link.sda_s_oe), .card_present(card_present),
      .over_current(over_current), .int_n(int_n), .vcc_on(vcc_on), .vcc_3v(vcc_3v), .card_rst(card_rst),
      .ctrl_byte(ctrl_byte));
   task automatic finish_test;
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= d;
      do @(posedge clk_sys); while (wb_ack !== 1'b1);
      res = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   // Start a link transfer and poll until it is over
   task automatic op(input logic [7:0] c);
      wb(1'b1, sc_pkg::WB_CMD, {24'h0, c});
      res = 32'h100;
      while (res[8] !== 1'b0) wb(1'b0, sc_pkg::WB_RESULT, 32'h0);
   endtask : op
   task automatic wr(input logic [7:0] v);
      wb(1'b1, sc_pkg::WB_DATA, {24'h0, v});
      op(8'h01);
   endtask : wr
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Card clock at its own rate and phase
   initial begin
      card_clk = 1'b0;
      #7;
      forever #32 card_clk = ~card_clk;
   end
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 100000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      {card_present, supply_fault, over_current, over_heat} = '0;
      card_drv = 3'b111;
      err_count = 0;
      n_compared = 0;
      cyc_n = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      op(8'h02);
      chk("addr nack", 8'h01, {7'h0, res[9]});
      wb(1'b1, sc_pkg::WB_ASEL, 32'h5);
      wb(1'b0, sc_pkg::WB_ASEL, 32'h0);
      chk("asel", 8'h05, res[7:0]);
      op(8'h02);
      chk("status reset", 8'h04, res[7:0]);
      card_present <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("insert int", 8'h00, {7'h0, int_n});
      wr(8'h85);
      chk("control", 8'h85, ctrl_byte);
      chk("vcc 3v", 8'h01, {7'h0, vcc_3v});
      while (card_rst !== 1'b1) @(posedge clk_sys);
      repeat (460 * 16) @(posedge clk_sys);
      card_drv <= 3'b110;
      repeat (8) @(posedge clk_sys);
      chk("relay", 8'h01, {7'h0, host_side_line_oe[0]});
      card_drv <= 3'b111;
      repeat (8) @(posedge clk_sys);
      op(8'h02);
      chk("status mute", 8'ha7, res[7:0]);
      chk("int released", 8'h01, {7'h0, int_n});
      wr(8'h00);
      chk("supply off", 8'h00, {7'h0, vcc_on});
      // Heat outside a session raises no protection flag
      over_heat <= 1'b1;
      repeat (8) @(posedge clk_sys);
      over_heat <= 1'b0;
      chk("heat idle int", 8'h01, {7'h0, int_n});
      wr(8'h81);
      while (card_rst !== 1'b1) @(posedge clk_sys);
      card_drv <= 3'b110;
      repeat (64) @(posedge clk_sys);
      card_drv <= 3'b111;
      chk("supply on", 8'h01, {7'h0, vcc_on});
      chk("vcc 5v", 8'h00, {7'h0, vcc_3v});
      over_current <= 1'b1;
      repeat (8) @(posedge clk_sys);
      supply_fault <= 1'b1;
      repeat (8) @(posedge clk_sys);
      over_current <= 1'b0;
      supply_fault <= 1'b0;
      chk("fault off", 8'h00, {7'h0, vcc_on});
      chk("fault int", 8'h00, {7'h0, int_n});
      op(8'h02);
      chk("status faults", 8'h5d, res[7:0]);
      finish_test();
   end
endmodule : tb
